// ---- bench/readout_mode_reset_control_test.sv ----
// self-checking bench for the readout mode and reset control block
`timescale 1ns/1ps
`include "rmrc_cfg.svh"
module readout_mode_reset_control_test;
    localparam logic [31:0] ID_VAL = 32'h5A3C_96E1; // arbitrary identification value
    logic clock, arst_n, tck, tms, tdi, tdo, tdoOe, extStart, frameTick, markerA, markerD, readoutClk;
    logic analogMarkerClockPad, digitalMarkerClockPad, frameCounterClear, rightColumnsToAnalogOut, scanPixelEn;
    logic refBufferDis, mainClockFromPll, powerPulseAmpEn, discPowerPulseEn, discTestEn, testLevelInjectEn;
    logic middleColumnsToAnalogOut, cmosClockSel, extraRowsEn, patternOnlyEn, readoutReset;
    logic [15:0] discIn, linePatternReg, discOut;
    logic [31:0] frameCount, rd;
    logic [7:0]  ana, dig;
    logic [3:0]  codes [2] = '{4'hF, 4'h7};
    int          miscompares, comparisons, pulses, base;
    assign ana = {frameCounterClear, rightColumnsToAnalogOut, scanPixelEn, refBufferDis, mainClockFromPll,
                  powerPulseAmpEn, discPowerPulseEn, discTestEn};
    assign dig = {testLevelInjectEn, middleColumnsToAnalogOut, cmosClockSel, extraRowsEn, 1'b0, patternOnlyEn, 2'b00};
    rmrc_top #(.IDCODE_VAL(ID_VAL)) rmrc_top_inst (
        .clock(clock), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe),
        .extStart(extStart), .frameTick(frameTick), .markerA(markerA), .markerD(markerD), .readoutClk(readoutClk),
        .discIn(discIn), .linePatternReg(linePatternReg), .discOut(discOut),
        .analogMarkerClockPad(analogMarkerClockPad), .digitalMarkerClockPad(digitalMarkerClockPad),
        .frameCounterClear(frameCounterClear), .rightColumnsToAnalogOut(rightColumnsToAnalogOut),
        .scanPixelEn(scanPixelEn), .refBufferDis(refBufferDis), .mainClockFromPll(mainClockFromPll),
        .powerPulseAmpEn(powerPulseAmpEn), .discPowerPulseEn(discPowerPulseEn), .discTestEn(discTestEn),
        .testLevelInjectEn(testLevelInjectEn), .middleColumnsToAnalogOut(middleColumnsToAnalogOut),
        .cmosClockSel(cmosClockSel), .extraRowsEn(extraRowsEn), .patternOnlyEn(patternOnlyEn),
        .readoutReset(readoutReset), .frameCount(frameCount));
    rmrc_host_model rmrc_host_model_inst (.clock(clock), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi),
        .extStart(extStart));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) if (arst_n === 1'b1 && readoutReset === 1'b1) pulses++;
    // ============================================================
    // shared tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] ir, input logic [31:0] val, input int n, output logic [31:0] old);
        rmrc_host_model_inst.scan(1'b1, {28'h0, ir}, 4, old);
        rmrc_host_model_inst.scan(1'b0, val, n, old);
    endtask
    task automatic tick();
        @(negedge clock);
        frameTick = 1'b1;
        @(negedge clock);
        frameTick = 1'b0;
        repeat (2) @(negedge clock);
    endtask
    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clock);
        miscompares++;
        complete_run();
    end
    // ============================================================
    // main sequence
    initial begin
        arst_n = 1'b0;
        frameTick = 1'b0;
        markerA = 1'b1;
        markerD = 1'b1;
        readoutClk = 1'b0;
        discIn = 16'h1234;
        linePatternReg = 16'hABCD;
        repeat (2) @(negedge clock);
        arst_n = 1'b1;
        repeat (4) @(negedge clock);
        rmrc_host_model_inst.walk(8'h1F, 6);
        wr(`RMRC_IR_ANA_MODE, 32'h0, 8, rd);
        check("analogue reset", 32'h0, rd);
        wr(`RMRC_IR_DIG_MODE, 32'h0, 8, rd);
        check("digital reset", 32'h0, rd);
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            wr(`RMRC_IR_ANA_MODE, 32'h1 << i, 8, rd);
            check("analogue out", 32'h1 << i, {24'h0, ana});
            wr(`RMRC_IR_DIG_MODE, 32'h1 << i, 8, rd);
            check("digital out", (32'h1 << i) & 32'hF4, {24'h0, dig});
            check("digital back", i == 0 ? 32'h0 : 32'h1 << (i - 1), rd);
            check("pads", i == 3 ? 32'h0 : 32'h3, {30'h0, analogMarkerClockPad, digitalMarkerClockPad});
            check("disc", {16'h0, i == 2 ? linePatternReg : discIn}, {16'h0, discOut});
        end
        $display("mode walk done");
        wr(`RMRC_IR_ANA_MODE, 32'h0, 8, rd);
        repeat (3) tick();
        check("frame count", 32'h3, frameCount);
        wr(`RMRC_IR_ANA_MODE, 32'h80, 8, rd);
        tick();
        check("frame clear", 32'h0, frameCount);
        $display("frame counter done");
        for (int e = 1; e >= 0; e--) begin
            wr(`RMRC_IR_DIG_MODE, e ? 32'h2 : 32'h0, 8, rd);
            base = pulses;
            rmrc_host_model_inst.startPulse(60);
            repeat (10) @(negedge clock);
            check("external start", e, pulses - base);
            wr(`RMRC_IR_DIG_MODE, e, 8, rd);
            check("config kept", e ? 32'h2 : 32'h0, rd);
            base = pulses;
            for (int k = 0; k < 3; k++) wr(`RMRC_IR_START, k == 1, 1, rd);
            check("scan start", e, pulses - base);
        end
        $display("start sources done");
        foreach (codes[k]) begin
            wr(codes[k], 32'hA5, 8, rd);
            check("bypass", 32'h4A, rd);
        end
        $display("bypass done");
        wr(`RMRC_IR_ANA_MODE, 32'h7F, 8, rd);
        wr(`RMRC_IR_DIG_MODE, 32'hF4, 8, rd);
        tick();
        arst_n = 1'b0;
        repeat (2) @(negedge clock);
        check("reset clears", 32'h0, {ana, dig, frameCount[15:0]});
        check("reset holds readout", 32'h1, {31'h0, readoutReset});
        arst_n = 1'b1;
        repeat (4) @(negedge clock);
        rmrc_host_model_inst.walk(8'h1F, 6);
        rmrc_host_model_inst.scan(1'b0, 32'h0, 32, rd);
        check("identification", ID_VAL, rd);
        $display("mid-run reset done");
        complete_run();
    end
endmodule
bind rmrc_top rmrc_checker #(.NUM_DISC(NUM_DISC)) rmrc_checker_inst (
    .clock, .arst_n, .tdoOe, .frameTick, .markerA, .markerD, .readoutClk, .discIn, .linePatternReg, .discOut,
    .analogMarkerClockPad, .digitalMarkerClockPad, .frameCounterClear, .rightColumnsToAnalogOut, .scanPixelEn,
    .refBufferDis, .mainClockFromPll, .powerPulseAmpEn, .discPowerPulseEn, .discTestEn, .testLevelInjectEn,
    .middleColumnsToAnalogOut, .cmosClockSel, .extraRowsEn, .patternOnlyEn, .readoutReset, .frameCount);

// ---- bench/rmrc_assertions.sv ----
// concurrent checks on the ports of the readout mode and reset control block
`timescale 1ns/1ps
`include "rmrc_cfg.svh"
module rmrc_checker #(
    parameter int NUM_DISC = 16
) (
    input wire logic                    clock,
    input wire logic                    arst_n,
    input wire logic                    tdoOe,
    input wire logic                    frameTick,
    input wire logic                    markerA,
    input wire logic                    markerD,
    input wire logic                    readoutClk,
    input wire logic [NUM_DISC-1:0]     discIn,
    input wire logic [NUM_DISC-1:0]     linePatternReg,
    input wire logic [NUM_DISC-1:0]     discOut,
    input wire logic                    analogMarkerClockPad,
    input wire logic                    digitalMarkerClockPad,
    input wire logic                    frameCounterClear,
    input wire logic                    rightColumnsToAnalogOut,
    input wire logic                    scanPixelEn,
    input wire logic                    refBufferDis,
    input wire logic                    mainClockFromPll,
    input wire logic                    powerPulseAmpEn,
    input wire logic                    discPowerPulseEn,
    input wire logic                    discTestEn,
    input wire logic                    testLevelInjectEn,
    input wire logic                    middleColumnsToAnalogOut,
    input wire logic                    cmosClockSel,
    input wire logic                    extraRowsEn,
    input wire logic                    patternOnlyEn,
    input wire logic                    readoutReset,
    input wire logic [`RMRC_CNT_W-1:0]  frameCount
);
    // ============================================================
    // configuration outputs seen as one word
    logic [12:0] modes;
    assign modes = {frameCounterClear, rightColumnsToAnalogOut, scanPixelEn, refBufferDis, mainClockFromPll,
                    powerPulseAmpEn, discPowerPulseEn, discTestEn, testLevelInjectEn, middleColumnsToAnalogOut,
                    cmosClockSel, extraRowsEn, patternOnlyEn};
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    // ============================================================
    // port relations
    disc_source_a: assert property ($past(arst_n) |->
        discOut == ($past(patternOnlyEn) ? $past(linePatternReg) : $past(discIn)))
        else $error("discriminator output from wrong source");
    pad_source_a: assert property ($past(arst_n) |->
        ({analogMarkerClockPad, digitalMarkerClockPad} == {$past(markerA), $past(markerD)}) ||
        ({analogMarkerClockPad, digitalMarkerClockPad} == {2{$past(readoutClk)}}))
        else $error("marker pads mix their sources");
    frame_step_a: assert property ($past(arst_n) && !$past(frameCounterClear) && !frameCounterClear |->
        frameCount == $past(frameCount) + ($past(frameTick) ? 32'h1 : 32'h0))
        else $error("frame counter did not follow frame ticks");
    frame_clear_a: assert property (frameCounterClear && $past(frameCounterClear) |->
        frameCount == 32'h0) else $error("frame counter not held at zero");
    power_on_pulse_a: assert property ($rose(arst_n) |->
        readoutReset ##1 readoutReset ##1 !readoutReset) else $error("power-on readout reset pulse wrong");
    start_pulse_a: assert property ($rose(readoutReset) |=> !readoutReset)
        else $error("start readout reset longer than one cycle");
    config_kept_a: assert property ($rose(readoutReset) |-> $stable(modes) ##1 $stable(modes))
        else $error("start changed the configuration");
    shift_quiet_a: assert property (tdoOe |-> $stable(modes))
        else $error("mode outputs moved while shifting");
    reset_values_a: assert property ($rose(arst_n) |->
        modes == 13'h0 && frameCount == 32'h0 && discOut == '0 && !analogMarkerClockPad && !digitalMarkerClockPad)
        else $error("outputs not cleared by reset");
    tap_reset_a: assert property ($rose(arst_n) |-> !tdoOe [*8])
        else $error("scan port left idle state after reset");
    cover property ($rose(frameCounterClear));
    cover property ($rose(readoutReset));
    cover property (patternOnlyEn && discOut == linePatternReg);
endmodule

// ---- bench/rmrc_host_model.sv ----
// scan controller and external start source facing the block
`timescale 1ns/1ps
module rmrc_host_model (
    input  wire logic  clock,
    input  wire logic  tdo,
    output logic       tck,
    output logic       tms,
    output logic       tdi,
    output logic       extStart
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        extStart = 1'b0;
    end
    // ============================================================
    // scan port; tck idles low, low phase 9 clocks and high phase 8 to clear the pin synchronisers
    task automatic step(input logic m, input logic d, output logic q);
        @(negedge clock);
        tms = m;
        tdi = d;
        repeat (8) @(negedge clock);
        q = tdo;
        tck = 1'b1;
        repeat (8) @(negedge clock);
        tck = 1'b0;
    endtask
    // outside a shift the data line toggles so a stale value is never mistaken for data
    task automatic walk(input logic [7:0] seq, input int n);
        logic q;
        for (int k = 0; k < n; k++) step(seq[k], ~tdi, q);
    endtask
    task automatic scan(input logic ir, input logic [31:0] din, input int n, output logic [31:0] dout);
        logic q;
        dout = 32'h0;
        walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        for (int k = 0; k < n; k++) begin
            step(k == n - 1, din[k], q);
            dout[k] = q;
        end
        walk(8'h01, 2);
    endtask
    // ============================================================
    // external start, active high, width in clocks
    task automatic startPulse(input int width);
        @(negedge clock);
        extStart = 1'b1;
        repeat (width) @(negedge clock);
        extStart = 1'b0;
    endtask
endmodule

// ---- common/rmrc_cfg.svh ----
// constants for the readout mode and reset control block
`ifndef RMRC_CFG_SVH
`define RMRC_CFG_SVH

`define RMRC_IR_W          4
`define RMRC_IR_IDCODE     4'hE
`define RMRC_IR_ANA_MODE   4'h1
`define RMRC_IR_DIG_MODE   4'h2
`define RMRC_IR_START      4'h3
`define RMRC_IR_BYPASS     4'hF
`define RMRC_IR_CAPTURE    4'h1

`define RMRC_MODE_W        8
`define RMRC_MODE_RST      8'h00
`define RMRC_DR_W          32
`define RMRC_CNT_W         32
`define RMRC_CNT_RST       32'h0000_0000
`define RMRC_CNT_ONE       32'h0000_0001

`define RMRC_ANA_FRAME_CLR 7
`define RMRC_ANA_RIGHT8    6
`define RMRC_ANA_SCANPIX   5
`define RMRC_ANA_BUFREF    4
`define RMRC_ANA_PLL       3
`define RMRC_ANA_AMP_PP    2
`define RMRC_ANA_DISC_PP   1
`define RMRC_ANA_DISC_TST  0

`define RMRC_DIG_VTEST_INJ 7
`define RMRC_DIG_MIDDLE8   6
`define RMRC_DIG_CMOS_CLK  5
`define RMRC_DIG_LINE_ROWS 4
`define RMRC_DIG_SPEAK     3
`define RMRC_DIG_PATT_ONLY 2
`define RMRC_DIG_EXT_START 1
`define RMRC_DIG_JTAG_STRT 0

`define RMRC_IDCODE_DEF    32'h0000_0001

`endif

// ---- common/rmrc_pkg.sv ----
// types shared by the readout mode and reset control block
package rmrc_pkg;
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
        TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } rmrc_tap_state_t;
endpackage

// ---- common/rmrc_tap_if.sv ----
// scan port events passed from the tap controller to the register core
`timescale 1ns/1ps
`include "rmrc_cfg.svh"
interface rmrc_tap_if;
    logic                   tckRise;
    logic                   tckFall;
    logic                   tdiBit;
    logic                   captureDr;
    logic                   shiftDr;
    logic                   updateDr;
    logic                   inShiftDr;
    logic                   inShiftIr;
    logic                   irOutBit;
    logic [`RMRC_IR_W-1:0]  instr;
    modport tap  (output tckRise, tckFall, tdiBit, captureDr, shiftDr, updateDr,
                  inShiftDr, inShiftIr, irOutBit, instr);
    modport core (input  tckRise, tckFall, tdiBit, captureDr, shiftDr, updateDr,
                  inShiftDr, inShiftIr, irOutBit, instr);
endinterface

// ---- hw/rmrc_tap.sv ----
// scan port tap controller with pin synchronisers and instruction register
`timescale 1ns/1ps
`include "rmrc_cfg.svh"
module rmrc_tap (
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic tck,
    input  wire logic tms,
    input  wire logic tdi,
    rmrc_tap_if.tap   bus
);
    typedef struct packed {
        logic [2:0]             tckSync;
        logic [1:0]             tmsSync;
        logic [1:0]             tdiSync;
        rmrc_pkg::rmrc_tap_state_t st;
        logic [`RMRC_IR_W-1:0]  irSh;
        logic [`RMRC_IR_W-1:0]  instr;
    } rmrc_tap_st_t;

    rmrc_tap_st_t s_reg;
    rmrc_tap_st_t s_next;
    logic         rise;
    logic         fall;
    logic         tmsBit;

    // =====================================================================
    // pin sampling: bit 0 is the first stage and feeds only bit 1
    assign rise   = s_reg.tckSync[1] & ~s_reg.tckSync[2];
    assign fall   = ~s_reg.tckSync[1] & s_reg.tckSync[2];
    assign tmsBit = s_reg.tmsSync[1];

    // =====================================================================
    // state machine and instruction register
    always_comb begin
        s_next         = s_reg;
        s_next.tckSync = {s_reg.tckSync[1:0], tck};
        s_next.tmsSync = {s_reg.tmsSync[0], tms};
        s_next.tdiSync = {s_reg.tdiSync[0], tdi};
        if (rise) begin
            unique case (s_reg.st)
                rmrc_pkg::TAP_RESET:    s_next.st = tmsBit ? rmrc_pkg::TAP_RESET : rmrc_pkg::TAP_IDLE;
                rmrc_pkg::TAP_IDLE:     s_next.st = tmsBit ? rmrc_pkg::TAP_SEL_DR : rmrc_pkg::TAP_IDLE;
                rmrc_pkg::TAP_SEL_DR:   s_next.st = tmsBit ? rmrc_pkg::TAP_SEL_IR : rmrc_pkg::TAP_CAP_DR;
                rmrc_pkg::TAP_CAP_DR:   s_next.st = tmsBit ? rmrc_pkg::TAP_EXIT1_DR : rmrc_pkg::TAP_SHIFT_DR;
                rmrc_pkg::TAP_SHIFT_DR: s_next.st = tmsBit ? rmrc_pkg::TAP_EXIT1_DR : rmrc_pkg::TAP_SHIFT_DR;
                rmrc_pkg::TAP_EXIT1_DR: s_next.st = tmsBit ? rmrc_pkg::TAP_UPD_DR : rmrc_pkg::TAP_PAUSE_DR;
                rmrc_pkg::TAP_PAUSE_DR: s_next.st = tmsBit ? rmrc_pkg::TAP_EXIT2_DR : rmrc_pkg::TAP_PAUSE_DR;
                rmrc_pkg::TAP_EXIT2_DR: s_next.st = tmsBit ? rmrc_pkg::TAP_UPD_DR : rmrc_pkg::TAP_SHIFT_DR;
                rmrc_pkg::TAP_UPD_DR:   s_next.st = tmsBit ? rmrc_pkg::TAP_SEL_DR : rmrc_pkg::TAP_IDLE;
                rmrc_pkg::TAP_SEL_IR:   s_next.st = tmsBit ? rmrc_pkg::TAP_RESET : rmrc_pkg::TAP_CAP_IR;
                rmrc_pkg::TAP_CAP_IR:   s_next.st = tmsBit ? rmrc_pkg::TAP_EXIT1_IR : rmrc_pkg::TAP_SHIFT_IR;
                rmrc_pkg::TAP_SHIFT_IR: s_next.st = tmsBit ? rmrc_pkg::TAP_EXIT1_IR : rmrc_pkg::TAP_SHIFT_IR;
                rmrc_pkg::TAP_EXIT1_IR: s_next.st = tmsBit ? rmrc_pkg::TAP_UPD_IR : rmrc_pkg::TAP_PAUSE_IR;
                rmrc_pkg::TAP_PAUSE_IR: s_next.st = tmsBit ? rmrc_pkg::TAP_EXIT2_IR : rmrc_pkg::TAP_PAUSE_IR;
                rmrc_pkg::TAP_EXIT2_IR: s_next.st = tmsBit ? rmrc_pkg::TAP_UPD_IR : rmrc_pkg::TAP_SHIFT_IR;
                rmrc_pkg::TAP_UPD_IR:   s_next.st = tmsBit ? rmrc_pkg::TAP_SEL_DR : rmrc_pkg::TAP_IDLE;
            endcase
            unique case (s_reg.st)
                rmrc_pkg::TAP_RESET:    s_next.instr = `RMRC_IR_IDCODE;
                rmrc_pkg::TAP_CAP_IR:   s_next.irSh  = `RMRC_IR_CAPTURE;
                rmrc_pkg::TAP_SHIFT_IR: s_next.irSh  = {s_reg.tdiSync[1], s_reg.irSh[`RMRC_IR_W-1:1]};
                // the active instruction changes only here and in TAP_RESET; while shifting it is not valid yet
                rmrc_pkg::TAP_UPD_IR:   s_next.instr = s_reg.irSh;
                default:                s_next.instr = s_reg.instr;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_reg.tckSync <= 3'h0;
            s_reg.tmsSync <= 2'h3;
            s_reg.tdiSync <= 2'h0;
            s_reg.st      <= rmrc_pkg::TAP_RESET;
            s_reg.irSh    <= `RMRC_IR_CAPTURE;
            s_reg.instr   <= `RMRC_IR_IDCODE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.tckRise   = rise;
    assign bus.tckFall   = fall;
    assign bus.tdiBit    = s_reg.tdiSync[1];
    assign bus.captureDr = rise & (s_reg.st == rmrc_pkg::TAP_CAP_DR);
    assign bus.shiftDr   = rise & (s_reg.st == rmrc_pkg::TAP_SHIFT_DR);
    assign bus.updateDr  = rise & (s_reg.st == rmrc_pkg::TAP_UPD_DR);
    assign bus.inShiftDr = (s_reg.st == rmrc_pkg::TAP_SHIFT_DR);
    assign bus.inShiftIr = (s_reg.st == rmrc_pkg::TAP_SHIFT_IR);
    assign bus.irOutBit  = s_reg.irSh[0];
    assign bus.instr     = s_reg.instr;
endmodule

// ---- hw/rmrc_top.sv ----
// readout mode registers, scan data registers, start handling and frame counter
`timescale 1ns/1ps
`include "rmrc_cfg.svh"
module rmrc_top #(
    parameter int          NUM_DISC   = 16,
    parameter logic [31:0] IDCODE_VAL = `RMRC_IDCODE_DEF // arbitrary identification value
) (
    input  wire logic                  clock,
    input  wire logic                  arst_n,
    input  wire logic                  tck,
    input  wire logic                  tms,
    input  wire logic                  tdi,
    output logic                       tdo,
    output logic                       tdoOe,
    input  wire logic                  extStart,
    input  wire logic                  frameTick,
    input  wire logic                  markerA,
    input  wire logic                  markerD,
    input  wire logic                  readoutClk,
    input  wire logic [NUM_DISC-1:0]   discIn,
    input  wire logic [NUM_DISC-1:0]   linePatternReg,
    output logic [NUM_DISC-1:0]        discOut,
    output logic                       analogMarkerClockPad,
    output logic                       digitalMarkerClockPad,
    output logic                       frameCounterClear,
    output logic                       rightColumnsToAnalogOut,
    output logic                       scanPixelEn,
    output logic                       refBufferDis,
    output logic                       mainClockFromPll,
    output logic                       powerPulseAmpEn,
    output logic                       discPowerPulseEn,
    output logic                       discTestEn,
    output logic                       testLevelInjectEn,
    output logic                       middleColumnsToAnalogOut,
    output logic                       cmosClockSel,
    output logic                       extraRowsEn,
    output logic                       patternOnlyEn,
    output logic                       readoutReset,
    output logic [`RMRC_CNT_W-1:0]     frameCount
);
    typedef struct packed {
        logic [1:0]                extSync;
        logic                      extPrev;
        logic [`RMRC_DR_W-1:0]     drSh;
        logic [`RMRC_MODE_W-1:0]   anaMode;
        logic [`RMRC_MODE_W-1:0]   digMode;
        logic                      startBit;
        logic                      tdo;
        logic                      tdoOe;
        logic [`RMRC_CNT_W-1:0]    frameCnt;
        logic                      porDone;
        logic                      readoutRst;
        logic                      padA;
        logic                      padD;
        logic [NUM_DISC-1:0]       disc;
    } rmrc_core_st_t;

    rmrc_core_st_t c_reg;
    rmrc_core_st_t c_next;
    rmrc_tap_if    tapBus ();
    logic          extEdge;
    logic          scanStart;

    rmrc_tap u_tap (
        .clock  (clock),
        .arst_n (arst_n),
        .tck    (tck),
        .tms    (tms),
        .tdi    (tdi),
        .bus    (tapBus.tap)
    );

    // =====================================================================
    // start sources
    // only the rising edge counts, so the pulse width from the far side may vary freely
    assign extEdge   = c_reg.digMode[`RMRC_DIG_EXT_START] & c_reg.extSync[1] & ~c_reg.extPrev;
    // start fires when the scan bit falls back to 0 after a 1 was written
    assign scanStart = c_reg.digMode[`RMRC_DIG_JTAG_STRT] & tapBus.updateDr
                       & (tapBus.instr == `RMRC_IR_START)
                       & c_reg.startBit & ~c_reg.drSh[0];

    // =====================================================================
    // next state
    always_comb begin
        c_next         = c_reg;
        c_next.extSync = {c_reg.extSync[0], extStart};
        c_next.extPrev = c_reg.extSync[1];

        // scan data registers
        if (tapBus.captureDr) begin
            unique case (tapBus.instr)
                `RMRC_IR_IDCODE:   c_next.drSh = IDCODE_VAL;
                `RMRC_IR_ANA_MODE: c_next.drSh = {24'h000000, c_reg.anaMode};
                `RMRC_IR_DIG_MODE: c_next.drSh = {24'h000000, c_reg.digMode};
                `RMRC_IR_START:    c_next.drSh = {31'h00000000, c_reg.startBit};
                default:           c_next.drSh = `RMRC_CNT_RST;
            endcase
        end else if (tapBus.shiftDr) begin
            unique case (tapBus.instr)
                `RMRC_IR_IDCODE:   c_next.drSh = {tapBus.tdiBit, c_reg.drSh[31:1]};
                `RMRC_IR_ANA_MODE,
                `RMRC_IR_DIG_MODE: c_next.drSh = {24'h000000, tapBus.tdiBit, c_reg.drSh[7:1]};
                default:           c_next.drSh = {31'h00000000, tapBus.tdiBit};
            endcase
        end

        // mode registers load only at update, so outputs hold still while shifting
        if (tapBus.updateDr) begin
            unique case (tapBus.instr)
                `RMRC_IR_ANA_MODE: c_next.anaMode  = c_reg.drSh[`RMRC_MODE_W-1:0];
                `RMRC_IR_DIG_MODE: c_next.digMode  = c_reg.drSh[`RMRC_MODE_W-1:0];
                `RMRC_IR_START:    c_next.startBit = c_reg.drSh[0];
                // bypass and identification keep nothing past the scan itself
                default:           ;
            endcase
        end

        // scan output changes on the falling tck edge, enabled only in shift states
        if (tapBus.tckFall) begin
            c_next.tdoOe = tapBus.inShiftDr | tapBus.inShiftIr;
            if (tapBus.inShiftIr) begin
                c_next.tdo = tapBus.irOutBit;
            end else if (tapBus.inShiftDr) begin
                c_next.tdo = c_reg.drSh[0];
            end else begin
                c_next.tdo = 1'b0;
            end
        end

        // internal readout reset: once after power reset, then on each start
        c_next.porDone    = 1'b1;
        c_next.readoutRst = ~c_reg.porDone | extEdge | scanStart;

        // frame counter held at zero while the clear bit stays set
        if (c_reg.anaMode[`RMRC_ANA_FRAME_CLR]) begin
            c_next.frameCnt = `RMRC_CNT_RST;
        end else if (frameTick) begin
            c_next.frameCnt = c_reg.frameCnt + `RMRC_CNT_ONE;
        end

        // pad and discriminator steering, registered for clean outputs
        c_next.padA = c_reg.digMode[`RMRC_DIG_SPEAK] ? readoutClk : markerA;
        c_next.padD = c_reg.digMode[`RMRC_DIG_SPEAK] ? readoutClk : markerD;
        c_next.disc = c_reg.digMode[`RMRC_DIG_PATT_ONLY] ? linePatternReg : discIn;
    end

    // =====================================================================
    // state register: power reset clears every field except readoutRst, which it sets; configuration included
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            c_reg.extSync    <= 2'h0;
            c_reg.extPrev    <= 1'b0;
            c_reg.drSh       <= `RMRC_CNT_RST;
            c_reg.anaMode    <= `RMRC_MODE_RST;
            c_reg.digMode    <= `RMRC_MODE_RST;
            c_reg.startBit   <= 1'b0;
            c_reg.tdo        <= 1'b0;
            c_reg.tdoOe      <= 1'b0;
            c_reg.frameCnt   <= `RMRC_CNT_RST;
            c_reg.porDone    <= 1'b0;
            c_reg.readoutRst <= 1'b1;
            c_reg.padA       <= 1'b0;
            c_reg.padD       <= 1'b0;
            c_reg.disc       <= '0;
        end else begin
            c_reg <= c_next;
        end
    end

    // =====================================================================
    // outputs
    assign tdo                      = c_reg.tdo;
    assign tdoOe                    = c_reg.tdoOe;
    assign discOut                  = c_reg.disc;
    assign analogMarkerClockPad     = c_reg.padA;
    assign digitalMarkerClockPad    = c_reg.padD;
    assign frameCounterClear        = c_reg.anaMode[`RMRC_ANA_FRAME_CLR];
    assign rightColumnsToAnalogOut  = c_reg.anaMode[`RMRC_ANA_RIGHT8];
    assign scanPixelEn              = c_reg.anaMode[`RMRC_ANA_SCANPIX];
    assign refBufferDis             = c_reg.anaMode[`RMRC_ANA_BUFREF];
    assign mainClockFromPll         = c_reg.anaMode[`RMRC_ANA_PLL];
    assign powerPulseAmpEn          = c_reg.anaMode[`RMRC_ANA_AMP_PP];
    assign discPowerPulseEn         = c_reg.anaMode[`RMRC_ANA_DISC_PP];
    assign discTestEn               = c_reg.anaMode[`RMRC_ANA_DISC_TST];
    assign testLevelInjectEn        = c_reg.digMode[`RMRC_DIG_VTEST_INJ];
    assign middleColumnsToAnalogOut = c_reg.digMode[`RMRC_DIG_MIDDLE8];
    assign cmosClockSel             = c_reg.digMode[`RMRC_DIG_CMOS_CLK];
    assign extraRowsEn              = c_reg.digMode[`RMRC_DIG_LINE_ROWS];
    assign patternOnlyEn            = c_reg.digMode[`RMRC_DIG_PATT_ONLY];
    assign readoutReset             = c_reg.readoutRst;
    assign frameCount               = c_reg.frameCnt;
endmodule
